//--- design/pdm_top.sv
// Purpose: Port A/B/D registers and Port D alternate-function overrides
// Assumes: Peripheral override signals on core_clk; pins asynchronous
// Notes:   Registers over Avalon-MM with waitrequest, answer one cycle after request
//
// Notes on behaviour
// - Counter 0 external clock on D4 when clock-select bits two and one set.
// - D3 feeds external interrupt one with its input value.
// - D2 feeds external interrupt zero; shares serial clock and clock output.
// - Serial transfer clock on D2 only in synchronous transfer mode.
// - Transmit override: D1 output, pull-up overridden to 0, transmit data driven.
// - Receive enable: D0 input, pull-up value is latch bit and pull-up disable.
// - Serial clock output overrides D2 value; pull-up and direction stay normal.
// - Compare-B output overrides D5 value; pull-up and direction stay normal.
// - Digital input forced on for D6, D5, D4 when their function enabled.
// - Digital input forced on for D3, D2 on interrupt or clock input; none D1, D0.
// - Port A latch: bits two to zero read/write, upper bits zero, reset zero.
// - Port B direction: eight read/write bits reset to zero, all inputs.
// - Port A pin level: sampled levels on bits two to zero, upper bits zero.
//
// The register addresses and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pdm_regs.svh"

module pdm_top (
   input  wire logic              core_clk,
   input  wire logic              rstn,
   input  wire logic              ce,
   input  wire pdm_pkg::pdm_addr_t address,
   input  wire logic              read,
   input  wire logic              write,
   input  wire pdm_pkg::pdm_word_t writedata,
   input  wire pdm_pkg::pdm_be_t  byteenable,
   output pdm_pkg::pdm_word_t     readdata,
   output logic                   waitrequest,
   input  wire logic [2:0]        pa_in,
   output logic [2:0]             pa_out,
   output logic [2:0]             pa_oe,
   output logic [2:0]             pa_pu,
   input  wire logic [7:0]        pb_in,
   output logic [7:0]             pb_out,
   output logic [7:0]             pb_oe,
   output logic [7:0]             pb_pu,
   input  wire logic [6:0]        pd_in,
   output logic [6:0]             pd_out,
   output logic [6:0]             pd_oe,
   output logic [6:0]             pd_pu,
   input  wire logic              serial_tx_oe,
   input  wire logic              serial_tx_data,
   input  wire logic              serial_rx_en,
   input  wire logic              transfer_clock_out_enable,
   input  wire logic              transfer_clock_out_value,
   input  wire logic              transfer_clock_in_enable,
   input  wire logic              timer_compare_b_enable,
   input  wire logic              timer_compare_b_output,
   input  wire logic              capture_enable,
   input  wire logic              counter_one_enable,
   input  wire logic              ext_irq_zero_enable,
   input  wire logic              ext_irq_one_enable,
   output logic                   capture_input_pin,
   output logic                   counter_one_ext_clock_pin,
   output logic                   counter_zero_ext_clock_pin,
   output logic                   ext_irq_one_pin,
   output logic                   ext_irq_zero_pin,
   output logic                   serial_transfer_clock,
   output logic                   serial_rx_data
);
   import pdm_pkg::*;

   // ***********************************************
   // Declarations
   // ***********************************************
   localparam int NPIN = 18;

   pdm_bus_state_t bus_q;
   logic           wait_q;
   pdm_word_t      rdata_q;
   logic [2:0]     pa_latch_q;
   logic [2:0]     pa_dir_q;
   logic [7:0]     pb_latch_q;
   logic [7:0]     pb_dir_q;
   logic [6:0]     pd_latch_q;
   logic [6:0]     pd_dir_q;
   logic [1:0]     control_q;
   logic [2:0]     cnt0_q;
   logic           take;
   logic           wr_en;
   logic           global_pullup_disable;
   logic           sync_mode;
   logic           t0_en;
   logic           xck_en;
   logic [NPIN-1:0] pin_in_all;
   logic [NPIN-1:0] latch_all;
   logic [NPIN-1:0] dir_all;
   logic [NPIN-1:0] pullup_override_enable_all;
   logic [NPIN-1:0] pullup_override_value_all;
   logic [NPIN-1:0] direction_override_enable_all;
   logic [NPIN-1:0] direction_override_value_all;
   logic [NPIN-1:0] port_value_override_enable_all;
   logic [NPIN-1:0] port_value_override_value_all;
   logic [NPIN-1:0] digital_input_override_enable_all;
   logic [NPIN-1:0] digital_input_override_value_all;
   logic [NPIN-1:0] out_all;
   logic [NPIN-1:0] oe_all;
   logic [NPIN-1:0] pu_all;
   logic [NPIN-1:0] lvl_all;
   logic [2:0]      pa_lvl;
   logic [7:0]      pb_lvl;
   logic [6:0]      pd_lvl;
   logic [6:0]      fn_q;

   // Address match, used by every register decode
   function automatic logic hit(input pdm_addr_t a, input pdm_addr_t off);
      hit = (a == off);
   endfunction : hit

   // ***********************************************
   // Avalon-MM slave
   // ***********************************************
   // One request taken per idle phase; answer phase drops waitrequest once
   assign take  = ce && (bus_q == PDM_BUS_IDLE) && (read || write);
   assign wr_en = take && write && byteenable[0];

   // Answer sequencing
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         bus_q  <= PDM_BUS_IDLE;
         wait_q <= 1'b1;
      end else if (ce) begin
         case (bus_q)
            PDM_BUS_IDLE: begin
               if (read || write) begin
                  bus_q  <= PDM_BUS_ANSWER;
                  wait_q <= 1'b0;
               end
            end
            PDM_BUS_ANSWER: begin
               bus_q  <= PDM_BUS_IDLE;
               wait_q <= 1'b1;
            end
            default: begin
               bus_q  <= PDM_BUS_IDLE;
               wait_q <= 1'b1;
            end
         endcase
      end
   end

   // Read mux; unmapped addresses read zero, reserved bits zero
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         rdata_q <= 32'h0000_0000;
      end else if (take) begin
         rdata_q <= 32'h0000_0000;
         if (read) begin
            if (hit(address, `PDM_OFF_PA_LATCH)) rdata_q[2:0] <= pa_latch_q;
            if (hit(address, `PDM_OFF_PA_DIR))   rdata_q[2:0] <= pa_dir_q;
            if (hit(address, `PDM_OFF_PA_LEVEL)) rdata_q[2:0] <= pa_lvl;
            if (hit(address, `PDM_OFF_PB_LATCH)) rdata_q[7:0] <= pb_latch_q;
            if (hit(address, `PDM_OFF_PB_DIR))   rdata_q[7:0] <= pb_dir_q;
            if (hit(address, `PDM_OFF_PB_LEVEL)) rdata_q[7:0] <= pb_lvl;
            if (hit(address, `PDM_OFF_PD_LATCH)) rdata_q[6:0] <= pd_latch_q;
            if (hit(address, `PDM_OFF_PD_DIR))   rdata_q[6:0] <= pd_dir_q;
            if (hit(address, `PDM_OFF_PD_LEVEL)) rdata_q[6:0] <= pd_lvl;
            if (hit(address, `PDM_OFF_CONTROL))  rdata_q[1:0] <= control_q;
            if (hit(address, `PDM_OFF_CNT0_CTRL)) rdata_q[2:0] <= cnt0_q;
         end
      end
   end

   assign readdata    = rdata_q;
   assign waitrequest = wait_q;

   // ***********************************************
   // Port registers
   // ***********************************************
   // Port A: only three pins exist, upper bits are not stored
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         pa_latch_q <= `PDM_RST_PA;
         pa_dir_q   <= `PDM_RST_PA;
      end else if (wr_en) begin
         if (hit(address, `PDM_OFF_PA_LATCH)) pa_latch_q <= writedata[2:0];
         if (hit(address, `PDM_OFF_PA_DIR))   pa_dir_q   <= writedata[2:0];
      end
   end

   // Port B: full byte; direction resets so every pin starts as input
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         pb_latch_q <= `PDM_RST_PB;
         pb_dir_q   <= `PDM_RST_PB;
      end else if (wr_en) begin
         if (hit(address, `PDM_OFF_PB_LATCH)) pb_latch_q <= writedata[7:0];
         if (hit(address, `PDM_OFF_PB_DIR))   pb_dir_q   <= writedata[7:0];
      end
   end

   // Port D: seven pins
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         pd_latch_q <= `PDM_RST_PD;
         pd_dir_q   <= `PDM_RST_PD;
      end else if (wr_en) begin
         if (hit(address, `PDM_OFF_PD_LATCH)) pd_latch_q <= writedata[6:0];
         if (hit(address, `PDM_OFF_PD_DIR))   pd_dir_q   <= writedata[6:0];
      end
   end

   // Global control and counter-0 clock select
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         control_q <= `PDM_RST_CONTROL;
         cnt0_q    <= `PDM_RST_CNT0;
      end else if (wr_en) begin
         if (hit(address, `PDM_OFF_CONTROL))   control_q <= writedata[1:0];
         if (hit(address, `PDM_OFF_CNT0_CTRL)) cnt0_q    <= writedata[2:0];
      end
   end

   assign global_pullup_disable       = control_q[`PDM_CTL_PUD];
   assign sync_mode = control_q[`PDM_CTL_SYNC];
   assign t0_en     = cnt0_q[`PDM_CNT0_CS2] & cnt0_q[`PDM_CNT0_CS1];
   assign xck_en    = transfer_clock_in_enable & sync_mode;

   // ***********************************************
   // Override matrix
   // ***********************************************
   // Ports A and B carry no overrides here; Port D per its alternate functions
   always_comb begin
      pullup_override_enable_all  = '0;
      pullup_override_value_all  = '0;
      direction_override_enable_all  = '0;
      direction_override_value_all  = '0;
      port_value_override_enable_all  = '0;
      port_value_override_value_all  = '0;
      digital_input_override_enable_all = '0;
      digital_input_override_value_all = '0;
      // Transmit pin: output, pull-up off, data from transmitter
      pullup_override_enable_all[`PDM_PIN_BASE_PD+1] = serial_tx_oe;
      direction_override_enable_all[`PDM_PIN_BASE_PD+1] = serial_tx_oe;
      direction_override_value_all[`PDM_PIN_BASE_PD+1] = 1'b1;
      port_value_override_enable_all[`PDM_PIN_BASE_PD+1] = serial_tx_oe;
      port_value_override_value_all[`PDM_PIN_BASE_PD+1] = serial_tx_data;
      // Receive pin: input, pull-up kept only when latch and disable both set
      pullup_override_enable_all[`PDM_PIN_BASE_PD+0] = serial_rx_en;
      pullup_override_value_all[`PDM_PIN_BASE_PD+0] = pd_latch_q[0] & global_pullup_disable;
      direction_override_enable_all[`PDM_PIN_BASE_PD+0] = serial_rx_en;
      // Clock output: value only; blocked outside synchronous mode
      port_value_override_enable_all[`PDM_PIN_BASE_PD+2] = transfer_clock_out_enable & sync_mode;
      port_value_override_value_all[`PDM_PIN_BASE_PD+2] = transfer_clock_out_value;
      // Compare-B output: value only
      port_value_override_enable_all[`PDM_PIN_BASE_PD+5] = timer_compare_b_enable;
      port_value_override_value_all[`PDM_PIN_BASE_PD+5] = timer_compare_b_output;
      // Digital input forcing on function inputs
      digital_input_override_enable_all[`PDM_PIN_BASE_PD+6] = capture_enable;
      digital_input_override_enable_all[`PDM_PIN_BASE_PD+5] = counter_one_enable;
      digital_input_override_enable_all[`PDM_PIN_BASE_PD+4] = t0_en;
      digital_input_override_enable_all[`PDM_PIN_BASE_PD+3] = ext_irq_one_enable;
      digital_input_override_enable_all[`PDM_PIN_BASE_PD+2] = ext_irq_zero_enable | xck_en;
      digital_input_override_value_all[`PDM_PIN_BASE_PD+6] = 1'b1;
      digital_input_override_value_all[`PDM_PIN_BASE_PD+5] = 1'b1;
      digital_input_override_value_all[`PDM_PIN_BASE_PD+4] = 1'b1;
      digital_input_override_value_all[`PDM_PIN_BASE_PD+3] = 1'b1;
      digital_input_override_value_all[`PDM_PIN_BASE_PD+2] = 1'b1;
   end

   assign pin_in_all = {pd_in, pb_in, pa_in};
   assign latch_all  = {pd_latch_q, pb_latch_q, pa_latch_q};
   assign dir_all    = {pd_dir_q, pb_dir_q, pa_dir_q};

   // ***********************************************
   // Pin cells
   // ***********************************************
   generate
      for (genvar i = 0; i < NPIN; i++) begin : g_pin
         pdm_pin_cell u_cell (
            .core_clk (core_clk),
            .rstn     (rstn),
            .ce       (ce),
            .pin_in   (pin_in_all[i]),
            .latch    (latch_all[i]),
            .dir      (dir_all[i]),
            .global_pullup_disable      (global_pullup_disable),
            .pullup_override_enable     (pullup_override_enable_all[i]),
            .pullup_override_value     (pullup_override_value_all[i]),
            .direction_override_enable     (direction_override_enable_all[i]),
            .direction_override_value     (direction_override_value_all[i]),
            .port_value_override_enable     (port_value_override_enable_all[i]),
            .port_value_override_value     (port_value_override_value_all[i]),
            .digital_input_override_enable    (digital_input_override_enable_all[i]),
            .digital_input_override_value    (digital_input_override_value_all[i]),
            .pin_out  (out_all[i]),
            .pin_oe   (oe_all[i]),
            .pin_pu   (pu_all[i]),
            .pin_lvl  (lvl_all[i])
         );
      end
   endgenerate

   assign pa_out = out_all[2:0];
   assign pa_oe  = oe_all[2:0];
   assign pa_pu  = pu_all[2:0];
   assign pb_out = out_all[10:3];
   assign pb_oe  = oe_all[10:3];
   assign pb_pu  = pu_all[10:3];
   assign pd_out = out_all[17:11];
   assign pd_oe  = oe_all[17:11];
   assign pd_pu  = pu_all[17:11];
   assign pa_lvl = lvl_all[2:0];
   assign pb_lvl = lvl_all[10:3];
   assign pd_lvl = lvl_all[17:11];

   // ***********************************************
   // Peripheral inputs
   // ***********************************************
   // Delivered only while the function is enabled, so idle peripherals see zero
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         fn_q <= 7'h00;
      end else if (ce) begin
         fn_q[6] <= pd_lvl[6] & capture_enable;
         fn_q[5] <= pd_lvl[5] & counter_one_enable;
         fn_q[4] <= pd_lvl[4] & t0_en;
         fn_q[3] <= pd_lvl[3] & ext_irq_one_enable;
         fn_q[2] <= pd_lvl[2] & ext_irq_zero_enable;
         fn_q[1] <= pd_lvl[2] & xck_en;
         fn_q[0] <= pd_lvl[0] & serial_rx_en;
      end
   end

   assign capture_input_pin          = fn_q[6];
   assign counter_one_ext_clock_pin  = fn_q[5];
   assign counter_zero_ext_clock_pin = fn_q[4];
   assign ext_irq_one_pin            = fn_q[3];
   assign ext_irq_zero_pin           = fn_q[2];
   assign serial_transfer_clock      = fn_q[1];
   assign serial_rx_data             = fn_q[0];

   // ***********************************************
   // Assertions
   // ***********************************************
   sequence s_write_to(pdm_addr_t off);
      ce && wait_q && write && byteenable[0] && address == off;
   endsequence

   sequence s_read_done(pdm_addr_t off);
      read && !wait_q && address == off;
   endsequence

   chk_tx_drive: assert property (@(posedge core_clk) disable iff (!rstn)
      ce && serial_tx_oe |=> pd_oe[1] && !pd_pu[1] && pd_out[1] == $past(serial_tx_data))
      else $error("transmit override not applied");

   chk_rx_input: assert property (@(posedge core_clk) disable iff (!rstn)
      ce && serial_rx_en |=> !pd_oe[0] && pd_pu[0] == $past(pd_latch_q[0] & global_pullup_disable))
      else $error("receive override not applied");

   chk_xck_mode: assert property (@(posedge core_clk) disable iff (!rstn)
      ce && !sync_mode |=> pd_out[2] == $past(pd_latch_q[2]) && !serial_transfer_clock)
      else $error("transfer clock active outside synchronous mode");

   chk_xck_value: assert property (@(posedge core_clk) disable iff (!rstn)
      ce && sync_mode && transfer_clock_out_enable
      |=> pd_out[2] == $past(transfer_clock_out_value) && pd_oe[2] == $past(pd_dir_q[2]))
      else $error("clock output override wrong");

   chk_cmpb_value: assert property (@(posedge core_clk) disable iff (!rstn)
      ce && timer_compare_b_enable
      |=> pd_out[5] == $past(timer_compare_b_output) && pd_oe[5] == $past(pd_dir_q[5]))
      else $error("compare-B override wrong");

   chk_t0_source: assert property (@(posedge core_clk) disable iff (!rstn)
      ce |=> counter_zero_ext_clock_pin == $past(pd_lvl[4] & cnt0_q[2] & cnt0_q[1]))
      else $error("counter 0 clock source wrong");

   chk_irq_source: assert property (@(posedge core_clk) disable iff (!rstn)
      ce |=> ext_irq_one_pin == $past(pd_lvl[3] & ext_irq_one_enable)
             && ext_irq_zero_pin == $past(pd_lvl[2] & ext_irq_zero_enable))
      else $error("interrupt pin value wrong");

   chk_bus_answer: assert property (@(posedge core_clk) disable iff (!rstn)
      ce && wait_q && (read || write) |=> !waitrequest ##1 (waitrequest || !$past(ce)))
      else $error("bus answer timing wrong");

   chk_pa_latch: assert property (@(posedge core_clk) disable iff (!rstn)
      s_write_to(`PDM_OFF_PA_LATCH) |=> pa_latch_q == $past(writedata[2:0]))
      else $error("port A latch write lost");

   chk_pa_upper: assert property (@(posedge core_clk) disable iff (!rstn)
      s_read_done(`PDM_OFF_PA_LEVEL) or s_read_done(`PDM_OFF_PA_LATCH)
      |-> readdata[31:3] == 29'h0)
      else $error("port A upper bits not zero");

   chk_pb_dir: assert property (@(posedge core_clk) disable iff (!rstn)
      s_write_to(`PDM_OFF_PB_DIR) |=> pb_dir_q == $past(writedata[7:0]) && !waitrequest)
      else $error("port B direction write lost");

endmodule : pdm_top

`default_nettype wire

//--- design/pdm_regs.svh
// Purpose: Register offsets, field positions and reset values of the pin override block
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, one register per aligned word
// Notes:   Included by bare name; definitions only
`ifndef PDM_REGS_SVH
`define PDM_REGS_SVH

// ***********************************************
// Register offsets (byte addresses)
// ***********************************************
`define PDM_OFF_PA_LATCH  6'h00
`define PDM_OFF_PA_DIR    6'h04
`define PDM_OFF_PA_LEVEL  6'h08
`define PDM_OFF_PB_LATCH  6'h0c
`define PDM_OFF_PB_DIR    6'h10
`define PDM_OFF_PB_LEVEL  6'h14
`define PDM_OFF_PD_LATCH  6'h18
`define PDM_OFF_PD_DIR    6'h1c
`define PDM_OFF_PD_LEVEL  6'h20
`define PDM_OFF_CONTROL   6'h24
`define PDM_OFF_CNT0_CTRL 6'h28

// ***********************************************
// Reset values
// ***********************************************
`define PDM_RST_PA        3'h0
`define PDM_RST_PB        8'h00
`define PDM_RST_PD        7'h00
`define PDM_RST_CONTROL   2'h0
`define PDM_RST_CNT0      3'h0

// ***********************************************
// Field positions
// ***********************************************
`define PDM_CTL_PUD       0
`define PDM_CTL_SYNC      1
`define PDM_CNT0_CS1      1
`define PDM_CNT0_CS2      2
`define PDM_PIN_BASE_PB   3
`define PDM_PIN_BASE_PD   11

`endif

//--- design/pdm_pkg.sv
// Purpose: Shared types of the pin override block
// Assumes: Offsets and counts live in pdm_regs.svh
// Notes:   Types only
package pdm_pkg;

   typedef logic [5:0]  pdm_addr_t;
   typedef logic [31:0] pdm_word_t;
   typedef logic [3:0]  pdm_be_t;

   // Bus answer phases
   typedef enum logic {
      PDM_BUS_IDLE,
      PDM_BUS_ANSWER
   } pdm_bus_state_t;

endpackage : pdm_pkg

//--- design/pdm_pin_cell.sv
// Purpose: One pin: input synchroniser and override selection of pull-up, direction, value
// Assumes: Override signals come from logic on core_clk
// Notes:   Value, direction and pull-up outputs registered; pin level gated by digital input enable
`timescale 1ns/1ps
`default_nettype none

module pdm_pin_cell (
   input  wire logic core_clk,
   input  wire logic rstn,
   input  wire logic ce,
   input  wire logic pin_in,
   input  wire logic latch,
   input  wire logic dir,
   input  wire logic global_pullup_disable,
   input  wire logic pullup_override_enable,
   input  wire logic pullup_override_value,
   input  wire logic direction_override_enable,
   input  wire logic direction_override_value,
   input  wire logic port_value_override_enable,
   input  wire logic port_value_override_value,
   input  wire logic digital_input_override_enable,
   input  wire logic digital_input_override_value,
   output var  logic pin_out,
   output var  logic pin_oe,
   output var  logic pin_pu,
   output logic      pin_lvl
);

   logic sync1_q;
   logic sync2_q;
   logic sync3_q;
   logic flt_q;
   logic die_q;

   // Three-stage synchroniser; a change counts once stages two and three agree
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         sync3_q <= 1'b0;
         flt_q   <= 1'b0;
      end else if (ce) begin
         sync1_q <= pin_in;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         if (sync2_q == sync3_q) begin
            flt_q <= sync3_q;
         end
      end
   end

   // Enable picks the override, else normal port control
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         pin_out <= 1'b0;
         pin_oe  <= 1'b0;
         pin_pu  <= 1'b0;
         die_q   <= 1'b1;
      end else if (ce) begin
         pin_out <= port_value_override_enable ? port_value_override_value : latch;
         pin_oe  <= direction_override_enable ? direction_override_value : dir;
         pin_pu  <= pullup_override_enable ? pullup_override_value : (latch & ~dir & ~global_pullup_disable);
         die_q   <= digital_input_override_enable ? digital_input_override_value : 1'b1;
      end
   end

   // Disabled digital input reads low, never floating
   assign pin_lvl = flt_q & die_q;

endmodule : pdm_pin_cell

`default_nettype wire

//--- tb/testbench.sv
// Purpose: Self-checking bench for the Port D override block and port registers
// Assumes: Avalon answer one cycle after take; pin filter settles within 8 cycles
// Notes:   Bus tasks hold each request until waitrequest is sampled low
`timescale 1ns/1ps
`default_nettype none
`include "pdm_regs.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_errors++; \
   $display("[ERR] %0t mismatch got %h exp %h", $time, (a), (e)); end end

module testbench;
   import pdm_pkg::*;
   logic      core_clk = 0, rstn = 0, ce = 1, read = 0, write = 0;
   pdm_addr_t address = '0;
   pdm_word_t writedata = '0, readdata, rd;
   pdm_be_t   byteenable = 4'h1;
   logic      waitrequest;
   logic [2:0] pa_in = 3'h5, pa_out, pa_oe, pa_pu;
   logic [7:0] pb_in = 8'h3c, pb_out, pb_oe, pb_pu;
   logic [6:0] pd_in = 7'h7f, pd_out, pd_oe, pd_pu;
   logic tx_oe = 0, tx_d = 0, rx_en = 0, xo_en = 0, xo_v = 0, xi_en = 0, cb_en = 0, cb_o = 0;
   logic cap_en = 0, c1_en = 0, i0_en = 0, i1_en = 0;
   logic cap_p, c1_p, c0_p, i1_p, i0_p, sclk_p, rx_p;
   int   n_errors = 0, n_compared = 0;

   pdm_top i_pdm_top (.core_clk(core_clk), .rstn(rstn), .ce(ce), .address(address),
      .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest), .pa_in(pa_in), .pa_out(pa_out),
      .pa_oe(pa_oe), .pa_pu(pa_pu), .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe),
      .pb_pu(pb_pu), .pd_in(pd_in), .pd_out(pd_out), .pd_oe(pd_oe), .pd_pu(pd_pu),
      .serial_tx_oe(tx_oe), .serial_tx_data(tx_d), .serial_rx_en(rx_en),
      .transfer_clock_out_enable(xo_en), .transfer_clock_out_value(xo_v),
      .transfer_clock_in_enable(xi_en), .timer_compare_b_enable(cb_en),
      .timer_compare_b_output(cb_o), .capture_enable(cap_en), .counter_one_enable(c1_en),
      .ext_irq_zero_enable(i0_en), .ext_irq_one_enable(i1_en), .capture_input_pin(cap_p),
      .counter_one_ext_clock_pin(c1_p), .counter_zero_ext_clock_pin(c0_p),
      .ext_irq_one_pin(i1_p), .ext_irq_zero_pin(i0_p), .serial_transfer_clock(sclk_p),
      .serial_rx_data(rx_p));

   // 100 MHz clock
   always #5 core_clk = ~core_clk;

   // One Avalon access; waits for waitrequest low, never a fixed count
   task automatic bus(input logic wr, input pdm_addr_t a, input logic [7:0] d);
      address <= a;
      writedata <= {24'h0, d};
      write <= wr;
      read <= ~wr;
      @(posedge core_clk);
      while (waitrequest !== 1'b0) begin
         @(posedge core_clk);
      end
      rd = readdata;
      write <= 1'b0;
      read <= 1'b0;
      // One idle edge, so a following call never re-raises a strobe in this step
      @(posedge core_clk);
   endtask : bus

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask : tick

   task automatic close_out();
      if (n_errors == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : close_out

   // Watchdog well beyond the hundred or so cycles the sequence needs
   initial begin
      #50us;
      n_errors++;
      close_out();
   end

   initial begin
      tick(8);
      rstn <= 1'b1;
      tick(1);
      bus(0, `PDM_OFF_PA_LATCH, 0); `CHK(rd, 32'h0)
      bus(0, `PDM_OFF_PB_DIR, 0);   `CHK(rd, 32'h0)
      `CHK(pb_oe, 8'h00)
      bus(1, `PDM_OFF_PA_LATCH, 8'hff); bus(0, `PDM_OFF_PA_LATCH, 0); `CHK(rd, 32'h7)
      `CHK(pa_out, 3'h7)
      `CHK(pa_pu, 3'h7)
      bus(1, `PDM_OFF_PB_DIR, 8'ha5); bus(0, `PDM_OFF_PB_DIR, 0); `CHK(rd, 32'ha5)
      `CHK(pb_oe, 8'ha5)
      // A write without its byte lane must leave the register alone
      byteenable <= 4'h0; bus(1, `PDM_OFF_PB_DIR, 8'hff); byteenable <= 4'h1;
      bus(0, `PDM_OFF_PB_DIR, 0); `CHK(rd, 32'ha5)
      bus(0, `PDM_OFF_PA_LEVEL, 0); `CHK(rd, 32'h5)
      bus(0, 6'h3c, 0); `CHK(rd, 32'h0)
      // Transmit override over a latch that would enable the pull-up
      bus(1, `PDM_OFF_PD_LATCH, 8'h03); tick(2); `CHK(pd_pu[1], 1'b1)
      tx_oe <= 1; tx_d <= 1; tick(2);
      `CHK(pd_oe[1], 1'b1)
      `CHK(pd_pu[1], 1'b0)
      `CHK(pd_out[1], 1'b1)
      tx_d <= 0; tick(2); `CHK(pd_out[1], 1'b0)
      tx_oe <= 0; tick(2); `CHK(pd_oe[1], 1'b0)
      // Clock enable low freezes the pin cells
      ce <= 0; tx_oe <= 1; tick(3); `CHK(pd_oe[1], 1'b0)
      ce <= 1; tx_oe <= 0;
      // Receiver forces input against a set direction bit
      bus(1, `PDM_OFF_PD_DIR, 8'h01); rx_en <= 1; tick(8);
      `CHK(pd_oe[0], 1'b0)
      `CHK(pd_pu[0], 1'b0)
      `CHK(rx_p, 1'b1)
      bus(1, `PDM_OFF_CONTROL, 8'h01); tick(2); `CHK(pd_pu[0], 1'b1)
      cb_en <= 1; cb_o <= 1; xo_en <= 1; xo_v <= 1;
      bus(1, `PDM_OFF_CONTROL, 8'h00); tick(2);
      `CHK(pd_out[5], 1'b1)
      `CHK(pd_oe[5], 1'b0)
      `CHK(pd_out[2], 1'b0)
      bus(1, `PDM_OFF_CONTROL, 8'h02); tick(2);
      `CHK(pd_out[2], 1'b1)
      `CHK(pd_oe[2], 1'b0)
      // Peripheral inputs from the filtered pin levels
      cap_en <= 1; c1_en <= 1; i0_en <= 1; i1_en <= 1; xi_en <= 1;
      bus(1, `PDM_OFF_CNT0_CTRL, 8'h04); tick(8);
      `CHK(c0_p, 1'b0)
      `CHK(cap_p, 1'b1)
      `CHK(c1_p, 1'b1)
      `CHK(i1_p, 1'b1)
      `CHK(i0_p, 1'b1)
      `CHK(sclk_p, 1'b1)
      bus(1, `PDM_OFF_CNT0_CTRL, 8'h06); tick(4); `CHK(c0_p, 1'b1)
      cap_en <= 0; i1_en <= 0; bus(1, `PDM_OFF_CONTROL, 8'h00); tick(4);
      `CHK(cap_p, 1'b0)
      `CHK(i1_p, 1'b0)
      `CHK(sclk_p, 1'b0)
      bus(0, `PDM_OFF_PD_LEVEL, 0); `CHK(rd, 32'h7f)
      close_out();
   end
endmodule : testbench
`default_nettype wire
